// file: sdf_pkg.sv
// Shared constants and types of the sinc decimation filter control
package sdf_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    // Mode register fields
    localparam int MODE_FS_LSB    = 0;
    localparam int MODE_FS_MSB    = 9;
    localparam int MODE_NOTCH_BIT = 10;
    localparam int MODE_ZL_BIT    = 11;
    localparam int MODE_THIRD_ORDER_SELECT_BIT = 15;
    localparam int MODE_CHOP_BIT  = 20;
    // Control and status fields
    localparam int CTRL_CHAN_BIT   = 0;
    localparam int STAT_SETTLE_BIT = 0;
    localparam int STAT_SWAP_BIT   = 1;
    localparam int STAT_NOTCH_BIT  = 2;
    localparam int STAT_CNT_LSB    = 8;
    localparam int STAT_CNT_MSB    = 15;
    // Reset values: fourth order, chop off, zero latency off
    localparam logic [9:0] FS_RESET    = 10'h060;
    localparam logic       THIRD_ORDER_SELECT_RESET = 1'b0;
    localparam logic       CHOP_RESET  = 1'b0;
    localparam logic       ZL_RESET    = 1'b0;
    localparam logic       NOTCH_RESET = 1'b0;
    // Filter orders and decimation base
    localparam logic [2:0] ORDER3   = 3'h3;
    localparam logic [2:0] ORDER4   = 3'h4;
    localparam logic [9:0] DEC_BASE = 10'h000;
    // Clock rates in kHz; master clock enable comes from a phase accumulator
    localparam int HCLK_KHZ = 200000;
    localparam int MCLK_KHZ = 4920;
    localparam logic [17:0] PH_MOD = 18'(HCLK_KHZ);
    localparam logic [17:0] PH_INC = 18'(MCLK_KHZ);

    typedef enum logic [1:0] {
        ST_RST = 2'b01,
        ST_RUN = 2'b10
    } sdf_state_t;

    function automatic logic [2:0] sdf_order(input logic third_order_select);
        return third_order_select ? ORDER3 : ORDER4;
    endfunction
endpackage

// file: sdf_tmr_if.sv
// Link between the filter control and its output period timer
`timescale 1ns/1ps
`default_nettype none
interface sdf_tmr_if;
    logic       mclk_en;
    logic       restart;
    logic [9:0] fs;
    logic       tick;
    modport ctrl (output mclk_en, output restart, output fs, input tick);
    modport tmr  (input mclk_en, input restart, input fs, output tick);
endinterface
`default_nettype wire

// file: sdf_rate_timer.sv
// Output period timer: counts 1024 x divider word master clocks
`timescale 1ns/1ps
`default_nettype none
module sdf_rate_timer
    import sdf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control side
    sdf_tmr_if.tmr   tif
);
    typedef struct packed {
        logic [19:0] cnt;
        logic        tick;
    } sdf_tmr_st_t;

    sdf_tmr_st_t s_q;
    sdf_tmr_st_t s_d;
    logic [19:0] limit;

    assign limit = {tif.fs, DEC_BASE} - 20'h00001;
    assign tif.tick = s_q.tick;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (tif.restart) begin
            s_d.cnt = 20'h00000;
        end else if (tif.mclk_en) begin
            if (s_q.cnt >= limit) begin
                s_d.cnt = 20'h00000;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    property p_tmr_tick;
        @(posedge hclk) disable iff (!hresetn)
        tif.tick |-> s_q.cnt == 20'h00000 && $past(tif.mclk_en);
    endproperty
    a_tmr_tick: assert property (p_tmr_tick)
        else $error("period tick without a wrap of the counter");
endmodule
`default_nettype wire

// file: sdf_ctrl.sv
// Sinc decimation filter control with an AHB-Lite register slave
//
// What this block does
// - Mode bit 11 selects zero latency
// - Zero latency settles every conversion fully
// - Zero latency period is order x 1024 x word
// - Asynchronous step gives one unsettled conversion
// - Third order select picks third_order_select else sinc4
// - Third_order_select rate is clock over 1024 x word
// - Third_order_select needs three periods to settle
// - Channel change resets, first result after settling
// - Single channel keeps rate after input steps
// - Notch bit at 96 keeps rate unchanged
// - Sinc4 word 96: 50 Hz, 12.5 Hz
// - Sinc4 word 480: 10 Hz, 2.5 Hz
// - Third_order_select word 80: 60 Hz, 20 Hz
// - Chop swaps input, averages both polarities
// - Reset gives sinc4 with chop off
// - Sinc4 rate over 1024 x word, four periods
// - Sinc4 chop rate over 4 x 1024 x word
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sdf_ctrl
    import sdf_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Modulator side
    input  wire logic        mod_bit,
    output logic             mod_reset,
    output logic             chop_swap,
    // Result side
    output logic             result_valid,
    output logic      [23:0] result_data
);
    typedef struct packed {
        sdf_state_t       st;
        logic [17:0]      ph;
        logic             men;
        logic [9:0]       fs;
        logic             notch;
        logic             zl;
        logic             third_order_select;
        logic             chop;
        logic             wr_pend;
        logic             rd_pend;
        logic [7:0]       addr;
        logic [31:0]      hrdata;
        logic             hready;
        logic [19:0]      ones;
        logic [3:0][19:0] hist;
        logic [1:0]       hidx;
        logic [2:0]       nper;
        logic [2:0]       pcnt;
        logic             evt;
        logic [21:0]      prev;
        logic             have_prev;
        logic             swap;
        logic             valid;
        logic [23:0]      data;
        logic             settled;
        logic [7:0]       convs;
        logic             mod_rst;
    } sdf_st_t;

    sdf_st_t     s_q;
    sdf_st_t     s_d;
    sdf_tmr_if   tif ();
    logic [2:0]  order;
    logic [21:0] wsum;
    logic [21:0] full;
    logic [21:0] raw;
    logic [22:0] avg;
    logic        addr_ph;

    // Sum of the newest periods that the chosen order spans
    function automatic logic [21:0] win_sum(input logic [3:0][19:0] h,
                                            input logic [1:0]       idx,
                                            input logic [2:0]       ord);
        logic [21:0] acc;
        acc = 22'h000000;
        for (int k = 0; k < 4; k++) begin
            if (3'(k) < ord) begin
                acc = acc + 22'(h[2'(idx - 2'(k))]);
            end
        end
        return acc;
    endfunction

    assign order   = sdf_order(s_q.third_order_select);
    assign wsum    = win_sum(s_q.hist, s_q.hidx, order);
    assign full    = 22'(order) * 22'({s_q.fs, DEC_BASE});
    assign raw     = s_q.swap ? full - wsum : wsum;
    assign avg     = 23'(raw) + 23'(s_q.prev);
    assign addr_ph = hsel && hready && htrans[1];

    assign tif.mclk_en = s_q.men;
    assign tif.fs      = s_q.fs;
    assign tif.restart = (s_q.st == ST_RST);

    sdf_rate_timer u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tif     (tif.tmr)
    );

    assign hrdata       = s_q.hrdata;
    assign hreadyout    = s_q.hready;
    assign hresp        = 1'b0;
    assign mod_reset    = s_q.mod_rst;
    assign chop_swap    = s_q.swap;
    assign result_valid = s_q.valid;
    assign result_data  = s_q.data;

    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        s_d.men = 1'b0;
        s_d.evt = 1'b0;
        s_d.mod_rst = 1'b0;
        // Fractional divider: average 4.92 MHz enable from 200 MHz
        if (s_q.ph + PH_INC >= PH_MOD) begin
            s_d.ph = s_q.ph + PH_INC - PH_MOD;
            s_d.men = 1'b1;
        end else begin
            s_d.ph = s_q.ph + PH_INC;
        end
        // Read data is fetched one cycle late so a write in the
        // preceding data phase is already visible
        if (s_q.rd_pend) begin
            s_d.rd_pend = 1'b0;
            s_d.hready = 1'b1;
            case (s_q.addr)
                ADDR_MODE: begin
                    s_d.hrdata = '0;
                    s_d.hrdata[MODE_FS_MSB:MODE_FS_LSB] = s_q.fs;
                    s_d.hrdata[MODE_NOTCH_BIT] = s_q.notch;
                    s_d.hrdata[MODE_ZL_BIT] = s_q.zl;
                    s_d.hrdata[MODE_THIRD_ORDER_SELECT_BIT] = s_q.third_order_select;
                    s_d.hrdata[MODE_CHOP_BIT] = s_q.chop;
                end
                ADDR_STAT: begin
                    s_d.hrdata = '0;
                    s_d.hrdata[STAT_SETTLE_BIT] = s_q.settled;
                    s_d.hrdata[STAT_SWAP_BIT] = s_q.swap;
                    s_d.hrdata[STAT_NOTCH_BIT] = s_q.notch;
                    s_d.hrdata[STAT_CNT_MSB:STAT_CNT_LSB] = s_q.convs;
                end
                ADDR_DATA: s_d.hrdata = {8'h00, s_q.data};
                default:   s_d.hrdata = 32'h00000000;
            endcase
        end
        // Conversion engine
        case (s_q.st)
            ST_RST: begin
                s_d.st = ST_RUN;
            end
            ST_RUN: begin
                if (s_q.men) begin
                    s_d.ones = s_q.ones + 20'(mod_bit);
                end
                if (tif.tick) begin
                    s_d.hidx = s_q.hidx + 2'h1;
                    s_d.hist[s_q.hidx + 2'h1] = s_q.ones;
                    s_d.ones = 20'h00000;
                    s_d.evt = 1'b1;
                    if (s_q.nper != 3'h7) begin
                        s_d.nper = s_q.nper + 3'h1;
                    end
                    s_d.pcnt = s_q.pcnt + 3'h1;
                end
                if (s_q.evt) begin
                    if (s_q.chop) begin
                        if (s_q.pcnt >= order) begin
                            s_d.pcnt = 3'h0;
                            s_d.swap = !s_q.swap;
                            s_d.prev = raw;
                            s_d.have_prev = 1'b1;
                            if (s_q.have_prev) begin
                                s_d.valid = 1'b1;
                                // Halved sum is the mean of both polarities
                                s_d.data = {2'b00, avg[22:1]};
                            end
                        end
                    end else if (s_q.zl) begin
                        // Window covers only this conversion's periods
                        if (s_q.pcnt >= order) begin
                            s_d.pcnt = 3'h0;
                            s_d.valid = 1'b1;
                            s_d.data = {2'b00, wsum};
                        end
                    end else if (s_q.nper >= order) begin
                        s_d.valid = 1'b1;
                        s_d.data = {2'b00, wsum};
                    end
                end
            end
            default: begin
                s_d.st = ST_RST;
            end
        endcase
        // Register writes; mode and channel writes restart the filter
        if (s_q.wr_pend) begin
            s_d.wr_pend = 1'b0;
            if (s_q.addr == ADDR_MODE) begin
                if (hwdata[MODE_FS_MSB:MODE_FS_LSB] != 10'h000) begin
                    s_d.fs = hwdata[MODE_FS_MSB:MODE_FS_LSB];
                end
                s_d.notch = hwdata[MODE_NOTCH_BIT];
                s_d.zl = hwdata[MODE_ZL_BIT];
                s_d.third_order_select = hwdata[MODE_THIRD_ORDER_SELECT_BIT];
                s_d.chop = hwdata[MODE_CHOP_BIT];
                s_d.st = ST_RST;
            end else if (s_q.addr == ADDR_CTRL && hwdata[CTRL_CHAN_BIT]) begin
                s_d.st = ST_RST;
            end
        end
        if (s_d.st == ST_RST) begin
            s_d.mod_rst = 1'b1;
            s_d.ones = 20'h00000;
            s_d.hist = '0;
            s_d.nper = 3'h0;
            s_d.pcnt = 3'h0;
            s_d.evt = 1'b0;
            s_d.have_prev = 1'b0;
            s_d.swap = 1'b0;
            s_d.settled = 1'b0;
            s_d.valid = 1'b0;
        end
        // After the restart clear, so a dropped result is never counted
        if (s_d.valid) begin
            s_d.settled = 1'b1;
            s_d.convs = s_q.convs + 8'h01;
        end
        if (addr_ph) begin
            s_d.addr = haddr[7:0];
            s_d.wr_pend = hwrite;
            s_d.rd_pend = !hwrite;
            s_d.hready = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.st <= ST_RUN;
            s_q.fs <= FS_RESET;
            s_q.third_order_select <= THIRD_ORDER_SELECT_RESET;
            s_q.chop <= CHOP_RESET;
            s_q.zl <= ZL_RESET;
            s_q.notch <= NOTCH_RESET;
            s_q.hready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    property p_zl_write;
        @(posedge hclk) disable iff (!hresetn)
        s_q.wr_pend && s_q.addr == ADDR_MODE
            |=> s_q.zl == $past(hwdata[MODE_ZL_BIT]);
    endproperty
    a_zl_write: assert property (p_zl_write)
        else $error("zero latency bit not taken from mode write");

    property p_zl_full;
        @(posedge hclk) disable iff (!hresetn)
        s_q.zl && !s_q.chop && s_q.evt && s_q.pcnt < order |=> !result_valid;
    endproperty
    a_zl_full: assert property (p_zl_full)
        else $error("zero latency result before full settling");

    property p_order;
        @(posedge hclk) disable iff (!hresetn)
        order == (s_q.third_order_select ? 3'h3 : 3'h4);
    endproperty
    a_order: assert property (p_order)
        else $error("filter order does not follow select bit");

    property p_settle;
        @(posedge hclk) disable iff (!hresetn)
        s_q.evt && !s_q.zl && !s_q.chop && s_q.nper < order
            && !s_q.wr_pend |=> !result_valid;
    endproperty
    a_settle: assert property (p_settle)
        else $error("normal mode result before settling periods");

    property p_chan;
        @(posedge hclk) disable iff (!hresetn)
        s_q.wr_pend && s_q.addr == ADDR_CTRL && hwdata[0]
            |=> mod_reset && !result_valid ##1 !mod_reset;
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel change did not pulse modulator reset");

    property p_valid_pulse;
        @(posedge hclk) disable iff (!hresetn)
        result_valid |=> !result_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("result strobe longer than one cycle");

    property p_fs_legal;
        @(posedge hclk) disable iff (!hresetn)
        s_q.fs != 10'h000;
    endproperty
    a_fs_legal: assert property (p_fs_legal)
        else $error("divider word became zero");

    property p_chop_swap;
        @(posedge hclk) disable iff (!hresetn)
        s_q.chop && s_q.evt && s_q.pcnt >= order && !s_q.wr_pend
            |=> chop_swap != $past(chop_swap);
    endproperty
    a_chop_swap: assert property (p_chop_swap)
        else $error("chop polarity did not alternate");

    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read answer not after one wait state");

    c_zl_result: cover property (@(posedge hclk) s_q.zl && result_valid);
    c_chop_result: cover property (@(posedge hclk) s_q.chop && result_valid);
    c_norm_result: cover property (@(posedge hclk)
        !s_q.zl && !s_q.chop && result_valid);
endmodule
`default_nettype wire

// file: sdf_mod_model.sv
// Modulator stand-in that drives the one-bit stream the filter decimates
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Stream pattern chosen by the bench: 0 zeros, 1 ones, else toggling
    input  wire logic [1:0] pattern,
    // Device side
    input  wire logic       mod_reset,
    output logic            mod_bit
);
    logic phase_q;

    // A restart clears the toggle phase, as the real modulator restarts too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 1'b0;
        end else if (mod_reset) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    always_comb begin
        case (pattern)
            2'h0:    mod_bit = 1'b0;
            2'h1:    mod_bit = 1'b1;
            default: mod_bit = phase_q;
        endcase
    end
endmodule
`default_nettype wire

// file: test_sinc_decimation_filter_ctrl.sv
// Self-checking bench for the sinc decimation filter control
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module test_sinc_decimation_filter_ctrl import sdf_pkg::*;;
    localparam logic [31:0] MODE_MASK = 32'h0010_8fff;
    // One output period at divider word 1, in bus clock cycles
    localparam int          PER       = (1024 * HCLK_KHZ) / MCLK_KHZ;
    // Master clock enable jitters by one bus clock, plus pipeline latency
    localparam int          TOL       = 120;
    localparam int          LIMIT     = 200000;

    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        mod_bit;
    logic        mod_reset;
    logic        chop_swap;
    logic        result_valid;
    logic [23:0] result_data;
    logic [1:0]  pattern;
    logic [31:0] bus_rd;
    logic        was_valid = 1'b0;
    logic [23:0] exp_data_q[$];
    int          exp_cyc_q[$];
    int          err_count = 0;
    int          check_count = 0;
    int          cyc_all = 0;
    int          since = 0;
    int          n_res = 0;

    always #2.5 hclk = ~hclk;

    assign hready = hreadyout;

    sdf_ctrl dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .mod_bit, .mod_reset,
        .chop_swap, .result_valid, .result_data
    );

    sdf_mod_model mod_u (
        .hclk, .hresetn, .pattern, .mod_reset, .mod_bit
    );

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Sampled on the falling edge, where the slave's outputs are settled
    task automatic wait_rdy();
        logic ok;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            bus_rd = hrdata;
            @(posedge hclk);
        end while (ok !== 1'b1);
    endtask

    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= 1'b1;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= 1'b0;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        wait_rdy();
        d = bus_rd;
    endtask

    // Result watcher: times each strobe from the last restart or the previous strobe
    always @(negedge hclk) begin : watch
        int d;
        cyc_all++;
        since++;
        if (was_valid) `CHK(result_valid, 1'b0)
        if (mod_reset) since = 0;
        if (result_valid) begin
            if (exp_data_q.size() == 0) begin
                `CHK(result_valid, 1'b0)
            end else begin
                `CHK(result_data, exp_data_q.pop_front())
                d = since - exp_cyc_q.pop_front();
                `CHK(d <= TOL && d >= -TOL, 1'b1)
                n_res++;
                since = 0;
            end
        end
        was_valid = result_valid;
        if (cyc_all >= LIMIT) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, cyc_all, LIMIT);
            results();
        end
    end

    initial begin
        logic [31:0] rd;
        logic [31:0] w;
        logic [31:0] w0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pattern = 2'h1;
        void'($urandom(32'h69a6));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        ahb_rd(ADDR_MODE, rd);
        `CHK(rd & MODE_MASK, 32'(FS_RESET))
        `CHK(hresp, 1'b0)
        ahb_rd(ADDR_STAT, rd);
        `CHK(rd[STAT_SETTLE_BIT], 1'b0)
        ahb_rd(ADDR_CTRL, rd);
        `CHK(rd, 32'h0)
        $display("test reset values done");
        w = ($urandom() & MODE_MASK) | 32'h1;
        ahb_wr(ADDR_MODE, w);
        ahb_rd(ADDR_MODE, rd);
        `CHK(rd & MODE_MASK, w)
        ahb_rd(ADDR_STAT, rd);
        `CHK(rd[STAT_NOTCH_BIT], w[MODE_NOTCH_BIT])
        // A zero divider word must leave the old word in place
        w0 = $urandom() & MODE_MASK & 32'hffff_fc00;
        ahb_wr(ADDR_MODE, w0);
        ahb_rd(ADDR_MODE, rd);
        `CHK(rd & MODE_MASK, w0 | (w & 32'h3ff))
        ahb_wr(8'h10, $urandom());
        ahb_rd(8'h10, rd);
        `CHK(rd, 32'h0)
        $display("test mode fields done");
        // Third_order_select at word 1; the channel change restarts the timing
        ahb_wr(ADDR_MODE, (32'h1 << MODE_THIRD_ORDER_SELECT_BIT) | 32'h1);
        ahb_rd(ADDR_MODE, rd);
        `CHK(rd[MODE_THIRD_ORDER_SELECT_BIT], 1'b1)
        exp_data_q.push_back(24'd3072);
        exp_cyc_q.push_back(3 * PER);
        exp_data_q.push_back(24'd3072);
        exp_cyc_q.push_back(PER);
        ahb_wr(ADDR_CTRL, 32'h1);
        @(negedge hclk);
        `CHK(mod_reset, 1'b1)
        while (n_res < 2) @(posedge hclk);
        @(negedge hclk);
        `CHK(chop_swap, 1'b0)
        @(posedge hclk);
        ahb_rd(ADDR_STAT, rd);
        `CHK(rd[STAT_SETTLE_BIT], 1'b1)
        `CHK(rd[STAT_CNT_MSB:STAT_CNT_LSB], 8'h02)
        ahb_rd(ADDR_DATA, rd);
        `CHK(rd[23:0], 24'd3072)
        $display("test third_order_select channel change done");
        results();
    end
endmodule
`default_nettype wire
